// [psr_top.sv]
// status, telemetry and configuration register bank of the power module
`timescale 1ns/1ps
module psr_top
    import psr_pkg::*;
#(
    parameter int MS_CYCLES = psr_pkg::PG_STEP_NS / psr_pkg::CLK_PERIOD_NS
) (
    input  wire logic                         clk_sys,
    input  wire logic                         reset_n,
    // decoded command port from the bus framing logic
    input  wire logic                         cmd_valid,
    input  wire logic                         cmd_write,
    input  wire logic [7:0]                   cmd_code,
    input  wire logic [15:0]                  cmd_wdata,
    input  wire logic                         cmd_bad_data,
    output logic                              rsp_valid,
    output logic [15:0]                       rsp_rdata,
    output logic                              rsp_unsupported,
    // analog comparator and strap pins
    input  wire logic [psr_pkg::FAULT_PINS-1:0] fault_cond_pins,
    input  wire logic                         power_good_raw,
    input  wire logic                         vin_uvlo_reached,
    input  wire logic                         operation_off,
    input  wire logic                         control_pin,
    input  wire logic [6:0]                   address_strap,
    // telemetry from the converter on this clock
    input  wire logic [9:0]                   vin_meas,
    input  wire logic [12:0]                  vout_meas,
    input  wire logic [13:0]                  iout_meas,
    input  wire logic [9:0]                   temp_meas,
    // configuration toward the converter
    output logic                              feedforward_cap_select,
    output logic [2:0]                        ramp_select,
    output logic                              slave_fault_detect_off,
    output logic                              active_discharge_enable,
    output logic                              discharge_on,
    output logic [3:0]                        power_good_delay,
    output logic [1:0]                        feedback_divider_select,
    output logic [1:0]                        switching_freq_select,
    output logic                              light_load_mode,
    output logic [6:0]                        bus_address,
    output logic [1:0]                        overvoltage_entry_level,
    output logic [1:0]                        overvoltage_exit_level,
    output logic                              power_good_out,
    output logic                              conversion_disabled,
    // open-drain alert toward the host
    output logic                              alert_output_o,
    output logic                              alert_output_oe
);
    import psr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    localparam int SYNC_W = FAULT_PINS + 11;

    logic [SYNC_W-1:0]     sync_out;
    logic [FAULT_PINS-1:0] fault_s;
    logic                  pg_raw_s;
    logic                  uvlo_ok_s;
    logic                  op_off_s;
    logic                  ctrl_s;
    logic [6:0]            strap_s;

    psr_pin_sync #(
        .W (SYNC_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .pin_in  ({address_strap, control_pin, operation_off, vin_uvlo_reached,
                   power_good_raw, fault_cond_pins}),
        .pin_out (sync_out)
    );

    assign fault_s   = sync_out[FAULT_PINS-1:0];
    assign pg_raw_s  = sync_out[FAULT_PINS];
    assign uvlo_ok_s = sync_out[FAULT_PINS+1];
    assign op_off_s  = sync_out[FAULT_PINS+2];
    assign ctrl_s    = sync_out[FAULT_PINS+3];
    assign strap_s   = sync_out[FAULT_PINS+10:FAULT_PINS+4];

    ////////////////////////////////////////////////////////////////////////////////
    // command decode

    logic       cmd_known;
    logic       cmd_writable;
    logic       do_write;
    logic       do_clear;
    logic       bad_cmd;
    logic [7:0] wbyte;

    always_comb
    begin
        cmd_known    = 1'b1;
        cmd_writable = 1'b0;
        unique case (cmd_code)
            CMD_COMP_CTRL, CMD_VOUT_CTRL, CMD_OPS_CTRL, CMD_ADDR_SELECT,
            CMD_OV_THRESHOLDS, CMD_OV_RESPONSE:
                cmd_writable = 1'b1;
            CMD_CLEAR_FAULTS, CMD_SUMMARY_BYTE, CMD_SUMMARY_WORD, CMD_OUTPUT_VOLTAGE_SUMMARY,
            CMD_OUTPUT_CURRENT_SUMMARY, CMD_INPUT_STATUS, CMD_TEMP_STATUS, CMD_COMMS_STATUS,
            CMD_VIN_READING, CMD_VOUT_READING, CMD_IOUT_READING, CMD_TEMP_READING:
                cmd_writable = 1'b0;
            default:
                cmd_known = 1'b0;
        endcase
    end

    assign wbyte    = cmd_wdata[7:0];
    assign do_write = cmd_valid & cmd_write & cmd_writable;
    assign do_clear = cmd_valid & cmd_write & (cmd_code == CMD_CLEAR_FAULTS);
    // a write to a read-only status or reading code is an unsupported command
    assign bad_cmd  = cmd_valid & (~cmd_known | (cmd_write & ~cmd_writable & ~do_clear)
                      | (~cmd_write & (cmd_code == CMD_CLEAR_FAULTS)));

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [7:0] comp_reg;
    logic [7:0] vctrl_reg;
    logic [7:0] ops_reg;
    logic [7:0] addr_reg;
    logic [7:0] ovth_reg;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (nw & mask);
    endfunction : merge

    // masks keep read-only bits at fixed values
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            comp_reg  <= COMP_RESET;
            vctrl_reg <= VCTRL_RESET;
            ops_reg   <= OPS_RESET;
            addr_reg  <= ADDR_RESET;
            ovth_reg  <= OVTH_RESET;
        end
        else if (do_write)
        begin
            if (cmd_code == CMD_COMP_CTRL)
                comp_reg <= merge(comp_reg, wbyte, COMP_MASK);
            if (cmd_code == CMD_VOUT_CTRL)
                vctrl_reg <= merge(vctrl_reg, wbyte, VCTRL_MASK);
            if (cmd_code == CMD_OPS_CTRL)
                ops_reg <= merge(ops_reg, wbyte, OPS_MASK);
            if (cmd_code == CMD_ADDR_SELECT)
                addr_reg <= merge(addr_reg, wbyte, ADDR_MASK);
            if (cmd_code == CMD_OV_THRESHOLDS)
                ovth_reg <= merge(ovth_reg, wbyte, OVTH_MASK);
        end
    end

    assign feedforward_cap_select  = comp_reg[COMP_CFF_BIT];
    assign ramp_select             = comp_reg[COMP_RAMP_LSB +: 3];
    assign slave_fault_detect_off  = comp_reg[COMP_SLAVE_BIT];
    // discharge only while control input low
    assign active_discharge_enable = vctrl_reg[VCTRL_DISCH_BIT];
    assign discharge_on            = vctrl_reg[VCTRL_DISCH_BIT] & ~ctrl_s;
    assign power_good_delay        = vctrl_reg[VCTRL_PGD_LSB +: 4];
    assign feedback_divider_select = vctrl_reg[VCTRL_RANGE_LSB +: 2];
    assign switching_freq_select   = ops_reg[OPS_FREQ_LSB +: 2];
    assign light_load_mode         = ops_reg[OPS_LL_BIT];
    assign bus_address             = addr_reg[ADDR_EN_BIT] ? addr_reg[6:0] : strap_s;
    assign overvoltage_entry_level = ovth_reg[OVTH_ENTRY_LSB +: 2];
    assign overvoltage_exit_level  = ovth_reg[OVTH_EXIT_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////////////
    // power-good delay timer

    localparam int PG_CNT_W = 24;

    logic [PG_CNT_W-1:0] pg_cnt_reg;
    logic [PG_CNT_W-1:0] pg_target;
    logic [4:0]          pg_ms;

    // 0000 gives 2 ms, one ms per code, 1111 gives 1 ms
    always_comb
    begin
        if (power_good_delay == PG_CODE_SHORT)
            pg_ms = 5'(PG_SHORT_MS);
        else
            pg_ms = 5'(PG_BASE_MS) + {1'b0, power_good_delay};
        pg_target = PG_CNT_W'(pg_ms) * PG_CNT_W'(MS_CYCLES);
    end

    // indication drops at once but rises only after the delay
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pg_cnt_reg     <= '0;
            power_good_out <= 1'b0;
        end
        else if (!pg_raw_s)
        begin
            pg_cnt_reg     <= '0;
            power_good_out <= 1'b0;
        end
        else if (pg_cnt_reg >= pg_target - PG_CNT_W'(1))
            power_good_out <= 1'b1;
        else
            pg_cnt_reg <= pg_cnt_reg + PG_CNT_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // flag conditions and latched bank

    psr_flag_if #(.N(NUM_FLAGS)) flag_bus ();

    logic signed [9:0] temp_signed;
    logic [NUM_FLAGS-1:0] fl;

    // the reading itself drives over-temperature detection
    assign temp_signed = signed'(temp_meas);

    always_comb
    begin
        flag_bus.cond                   = '0;
        flag_bus.cond[FAULT_PINS-1:0]   = fault_s;
        flag_bus.cond[F_OT_FAULT]       = (temp_signed >= OT_FAULT_LIMIT);
        flag_bus.cond[F_OT_WARN]        = (temp_signed >= OT_WARN_LIMIT);
        flag_bus.cond[F_CML_CMD]        = bad_cmd;
        flag_bus.cond[F_CML_DATA]       = cmd_valid & cmd_bad_data;
    end

    // clear-faults only acts on flags whose cause has gone
    assign flag_bus.clear = do_clear;
    assign fl             = flag_bus.flags;

    psr_flag_bank #(
        .N (NUM_FLAGS)
    ) u_flags (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .fb      (flag_bus)
    );

    // input flag starts set, clears itself at lockout threshold
    logic vin_startup_reg;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            vin_startup_reg <= 1'b1;
        else if (uvlo_ok_s)
            vin_startup_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status assembly

    logic [7:0]  output_voltage_summary;
    logic [7:0]  output_current_summary;
    logic [7:0]  input_status;
    logic [7:0]  temp_status;
    logic [7:0]  comms_status;
    logic [7:0]  summary_byte;
    logic [15:0] summary_word;

    assign output_voltage_summary  = {fl[F_OUTPUT_OVERVOLTAGE_FLAG], 2'b00, fl[F_VOUT_UV], fl[F_VOUT_LIM],
                           2'b00, fl[F_VOUT_OTH]};
    assign output_current_summary  = {fl[F_IOUT_OC], fl[F_IOUT_OCUV], fl[F_IOUT_WARN], 5'h00};
    assign input_status = {fl[F_VIN_OVF], fl[F_VIN_OVW], fl[F_VIN_UVW], fl[F_VIN_UVF],
                           4'h0};
    assign temp_status  = {fl[F_OT_FAULT], fl[F_OT_WARN], 6'h00};
    assign comms_status = {fl[F_CML_CMD], fl[F_CML_DATA], 1'b0, fl[F_MEM_FAULT],
                           2'b00, fl[F_CML_OTHER], fl[F_MEM_BUSY]};

    assign conversion_disabled = fault_s[F_VIN_UVF] | fault_s[F_VIN_OVF] | op_off_s;

    // summary byte from the latched flags, bit 6 from the unlatched conversion_disabled
    // temperature events feed the summary bit
    assign summary_byte = {1'b0, conversion_disabled, fl[F_OUTPUT_OVERVOLTAGE_FLAG], fl[F_IOUT_OC],
                           fl[F_VIN_UVF], |temp_status, |comms_status,
                           fl[F_UNKNOWN] | fl[F_VOUT_OTH]};

    // low byte mirrors summary byte, 12, 10, 9 zero
    assign summary_word = {|output_voltage_summary, |output_current_summary, (|input_status) | vin_startup_reg,
                           1'b0, ~power_good_out, 2'b00, fl[F_UNKNOWN], summary_byte};

    // alert pulled low while any flag is latched
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            alert_output_oe <= 1'b0;
        else
            alert_output_oe <= |fl;
    end

    assign alert_output_o = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    logic [15:0] rd_next;

    always_comb
    begin
        rd_next = 16'h0000;
        unique case (cmd_code)
            // single byte read of the summary
            CMD_SUMMARY_BYTE:  rd_next = {8'h00, summary_byte};
            CMD_SUMMARY_WORD:  rd_next = summary_word;
            CMD_OUTPUT_VOLTAGE_SUMMARY:   rd_next = {8'h00, output_voltage_summary};
            CMD_OUTPUT_CURRENT_SUMMARY:   rd_next = {8'h00, output_current_summary};
            CMD_INPUT_STATUS:  rd_next = {8'h00, input_status};
            CMD_TEMP_STATUS:   rd_next = {8'h00, temp_status};
            CMD_COMMS_STATUS:  rd_next = {8'h00, comms_status};
            CMD_VIN_READING:   rd_next = {6'h00, vin_meas};
            CMD_VOUT_READING:  rd_next = {3'h0, vout_meas};
            CMD_IOUT_READING:  rd_next = {2'h0, iout_meas};
            CMD_TEMP_READING:  rd_next = {6'h00, temp_meas};
            CMD_COMP_CTRL:     rd_next = {8'h00, comp_reg};
            CMD_VOUT_CTRL:     rd_next = {8'h00, vctrl_reg};
            CMD_OPS_CTRL:      rd_next = {8'h00, ops_reg};
            CMD_ADDR_SELECT:   rd_next = {8'h00, addr_reg};
            CMD_OV_THRESHOLDS: rd_next = {8'h00, ovth_reg};
            default:           rd_next = 16'h0000;
        endcase
    end

    // every command is answered one cycle later
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rsp_valid       <= 1'b0;
            rsp_rdata       <= 16'h0000;
            rsp_unsupported <= 1'b0;
        end
        else
        begin
            rsp_valid       <= cmd_valid;
            rsp_unsupported <= bad_cmd;
            if (cmd_valid && !cmd_write)
                rsp_rdata <= rd_next;
        end
    end

endmodule : psr_top

// [psr_pkg.sv]
// constants for the power-module status, telemetry and configuration bank
package psr_pkg;

    // command codes of the register bank
    localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
    localparam logic [7:0] CMD_SUMMARY_BYTE   = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_WORD   = 8'h79;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_SUMMARY    = 8'h7A;
    localparam logic [7:0] CMD_OUTPUT_CURRENT_SUMMARY    = 8'h7B;
    localparam logic [7:0] CMD_INPUT_STATUS   = 8'h7C;
    localparam logic [7:0] CMD_TEMP_STATUS    = 8'h7D;
    localparam logic [7:0] CMD_COMMS_STATUS   = 8'h7E;
    localparam logic [7:0] CMD_VIN_READING    = 8'h88;
    localparam logic [7:0] CMD_VOUT_READING   = 8'h8B;
    localparam logic [7:0] CMD_IOUT_READING   = 8'h8C;
    localparam logic [7:0] CMD_TEMP_READING   = 8'h8D;
    localparam logic [7:0] CMD_COMP_CTRL      = 8'hD0;
    localparam logic [7:0] CMD_VOUT_CTRL      = 8'hD1;
    localparam logic [7:0] CMD_OPS_CTRL       = 8'hD2;
    localparam logic [7:0] CMD_ADDR_SELECT    = 8'hD3;
    localparam logic [7:0] CMD_OV_THRESHOLDS  = 8'hD4;
    localparam logic [7:0] CMD_OV_RESPONSE    = 8'hD5;

    // reset values and writable-bit masks of the configuration registers
    localparam logic [7:0] COMP_RESET  = 8'h0D;
    localparam logic [7:0] COMP_MASK   = 8'hFF;
    localparam logic [7:0] VCTRL_RESET = 8'h00;
    localparam logic [7:0] VCTRL_MASK  = 8'hFF;
    localparam logic [7:0] OPS_RESET   = 8'h03;
    localparam logic [7:0] OPS_MASK    = 8'h07;
    localparam logic [7:0] ADDR_RESET  = 8'h50;
    localparam logic [7:0] ADDR_MASK   = 8'hFF;
    localparam logic [7:0] OVTH_RESET  = 8'h05;
    localparam logic [7:0] OVTH_MASK   = 8'h0F;

    // field positions
    localparam int COMP_CFF_BIT    = 4;
    localparam int COMP_RAMP_LSB   = 1;
    localparam int COMP_SLAVE_BIT  = 0;
    localparam int VCTRL_DISCH_BIT = 6;
    localparam int VCTRL_PGD_LSB   = 2;
    localparam int VCTRL_RANGE_LSB = 0;
    localparam int OPS_FREQ_LSB    = 1;
    localparam int OPS_LL_BIT      = 0;
    localparam int ADDR_EN_BIT     = 7;
    localparam int OVTH_EXIT_LSB   = 2;
    localparam int OVTH_ENTRY_LSB  = 0;

    // latched flag indexes
    localparam int F_OUTPUT_OVERVOLTAGE_FLAG    = 0;
    localparam int F_VOUT_UV    = 1;
    localparam int F_VOUT_LIM   = 2;
    localparam int F_VOUT_OTH   = 3;
    localparam int F_IOUT_OC    = 4;
    localparam int F_IOUT_OCUV  = 5;
    localparam int F_IOUT_WARN  = 6;
    localparam int F_VIN_OVF    = 7;
    localparam int F_VIN_OVW    = 8;
    localparam int F_VIN_UVW    = 9;
    localparam int F_VIN_UVF    = 10;
    localparam int F_MEM_FAULT  = 11;
    localparam int F_MEM_BUSY   = 12;
    localparam int F_CML_OTHER  = 13;
    localparam int F_UNKNOWN    = 14;
    localparam int F_OT_FAULT   = 15;
    localparam int F_OT_WARN    = 16;
    localparam int F_CML_CMD    = 17;
    localparam int F_CML_DATA   = 18;
    localparam int NUM_FLAGS    = 19;
    // the first FAULT_PINS flags come straight from comparator pins
    localparam int FAULT_PINS   = 15;

    // temperature limits and power-good delay timing
    localparam logic signed [9:0] OT_FAULT_LIMIT = 10'sd160;
    localparam logic signed [9:0] OT_WARN_LIMIT  = 10'sd140;
    localparam int PG_STEP_NS    = 1000000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int PG_BASE_MS    = 2;
    localparam logic [3:0] PG_CODE_SHORT = 4'hF;
    localparam int PG_SHORT_MS   = 1;

endpackage : psr_pkg

// [psr_flag_if.sv]
// carrier between the bank controller and the latched flag bank
`timescale 1ns/1ps
interface psr_flag_if #(
    parameter int N = 19
);
    logic [N-1:0] cond;
    logic         clear;
    logic [N-1:0] flags;

    modport ctrl (output cond, output clear, input flags);
    modport bank (input cond, input clear, output flags);
endinterface : psr_flag_if

// [psr_pin_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module psr_pin_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a bit only moves once stages two and three agree
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            pin_out <= '0;
        else
            pin_out <= (s2_reg & s3_reg) | (pin_out & (s2_reg ^ s3_reg));
    end
endmodule : psr_pin_sync

// [psr_flag_bank.sv]
// bank of sticky status flags with conditional clear
`timescale 1ns/1ps
module psr_flag_bank #(
    parameter int N = 19
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    psr_flag_if.bank  fb
);
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_flag
            // clear needs condition gone plus command; set wins
            always_ff @(posedge clk_sys or negedge reset_n)
            begin
                if (!reset_n)
                    fb.flags[i] <= 1'b0;
                else if (fb.cond[i])
                    fb.flags[i] <= 1'b1;
                else if (fb.clear)
                    fb.flags[i] <= 1'b0;
            end
        end
    endgenerate
endmodule : psr_flag_bank

// [psr_top_props.sv]
// assertions on the command port and the off input of the status and configuration bank
`timescale 1ns/1ps
module psr_top_props import psr_pkg::*; (
    input wire logic        clk_sys, reset_n, cmd_valid, cmd_write, rsp_valid,
    input wire logic        rsp_unsupported, operation_off, conversion_disabled,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] rsp_rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_rd(c); rsp_valid && !$past(cmd_write) && $past(cmd_code) == c; endsequence
    property p_ans; cmd_valid |=> rsp_valid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_quiet; !cmd_valid |=> !rsp_valid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_ro; cmd_valid && cmd_write && cmd_code == CMD_SUMMARY_BYTE
        |=> rsp_unsupported; endproperty
    a_ro: assert property (p_ro) else $error("read-only write taken");
    property p_byte; s_rd(CMD_SUMMARY_BYTE) |-> !rsp_rdata[7]; endproperty
    a_byte: assert property (p_byte) else $error("summary bit 7 set");
    property p_word; s_rd(CMD_SUMMARY_WORD) |-> (rsp_rdata & 16'h1600) == 16'h0000; endproperty
    a_word: assert property (p_word) else $error("word fixed bits set");
    property p_vin; s_rd(CMD_VIN_READING) |-> rsp_rdata[15:10] == 6'h00; endproperty
    a_vin: assert property (p_vin) else $error("input reading upper bits");
    property p_temp; s_rd(CMD_TEMP_STATUS) |-> rsp_rdata[5:0] == 6'h00; endproperty
    a_temp: assert property (p_temp) else $error("temperature low bits");
    property p_off; $rose(operation_off) |-> ##[2:6] conversion_disabled; endproperty
    a_off: assert property (p_off) else $error("off not reported");
endmodule : psr_top_props
bind psr_top psr_top_props u_props (.*);

// [psr_host_model.sv]
// host model issuing one command at a time on the command port
`timescale 1ns/1ps
module psr_host_model (
    input  wire logic        clk_sys, rsp_valid, rsp_unsupported,
    input  wire logic [15:0] rsp_rdata,
    output logic             cmd_valid, cmd_write,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata
);
    initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = '0;
    // one-cycle strobe, answer taken at the edge where it stands
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] q, output logic [1:0] r);
        @(posedge clk_sys) #2;
        {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
        // taken at this edge; holding the strobe longer would issue a second command
        @(posedge clk_sys) #2;
        {cmd_valid, cmd_wdata} = {1'b0, ~d};
        @(posedge clk_sys);
        {r, q} = {rsp_valid, rsp_unsupported, rsp_rdata};
        #2;
    endtask : xfer
endmodule : psr_host_model

// [pmbus_status_telemetry_config_regs_bench.sv]
// self-checking bench for the status and configuration bank
`timescale 1ns/1ps
module pmbus_status_telemetry_config_regs_bench;
    import psr_pkg::*;
    logic clk_sys = 0, reset_n = 0, cmd_bad_data = 0, power_good_raw = 0, control_pin = 0;
    logic vin_uvlo_reached = 0, operation_off = 0, cmd_valid, cmd_write, rsp_valid;
    logic rsp_unsupported, alert_output_o, alert_output_oe, feedforward_cap_select;
    logic slave_fault_detect_off, active_discharge_enable, discharge_on, light_load_mode;
    logic power_good_out, conversion_disabled;
    logic [1:0] feedback_divider_select, switching_freq_select, overvoltage_entry_level;
    logic [1:0] overvoltage_exit_level;
    logic [2:0] ramp_select;
    logic [3:0] power_good_delay;
    logic [6:0] bus_address, address_strap = 7'h2A;
    logic [7:0] cmd_code, dflt [5] = '{8'h0D, 8'h00, 8'h03, 8'h50, 8'h05};
    logic [9:0] vin_meas = 10'h3FF, temp_meas = 10'h000;
    logic [12:0] vout_meas = 13'h1FFF;
    logic [13:0] iout_meas = 14'h3FFF;
    logic [14:0] fault_cond_pins = '0;
    logic [15:0] cmd_wdata, rsp_rdata, q;
    logic [1:0] r;
    logic [7:0] f;
    int miscompares = 0, n_tests = 0;
    psr_top #(.MS_CYCLES(10)) u_dut (.*);
    psr_host_model u_host (.*);
    initial forever #25 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [15:0] s, e);
        n_tests++;
        if (s !== e) miscompares++;
        if (s !== e) $display("ERROR %s expected %h seen %h", nm, e, s);
    endtask : chk
    task automatic ac(input logic w, input logic [7:0] c, input logic [15:0] d, e);
        u_host.xfer(w, c, d, q, r);
        chk("answer strobe", 16'(r[1]), 16'h0001);
        if (!w) chk($sformatf("code %h", c), q, e);
    endtask : ac
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial
    begin
        #100000 miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (12) @(posedge clk_sys);
        #2 reset_n = 1'b1;
        foreach (dflt[i])
            ac(0, CMD_COMP_CTRL + 8'(i), 0, {8'h00, dflt[i]});
        ac(0, CMD_SUMMARY_WORD, 0, 16'h2800);
        {vin_uvlo_reached, power_good_raw} = 2'b11;
        #600;
        ac(0, CMD_SUMMARY_WORD, 0, 16'h0800);
        #600;
        ac(0, CMD_SUMMARY_WORD, 0, 16'h0000);
        chk("strap address", 16'(bus_address), 16'h002A);
        ac(1, CMD_OPS_CTRL, 16'hFFFF, 0);
        ac(0, CMD_OPS_CTRL, 0, 16'h0007);
        chk("ops fields", 16'({switching_freq_select, light_load_mode}), 16'h0007);
        chk("supported", 16'(r[0]), 16'h0000);
        ac(1, CMD_ADDR_SELECT, 16'h0085, 0);
        chk("register address", 16'(bus_address), 16'h0005);
        ac(1, CMD_COMP_CTRL, 16'h0013, 0);
        f = {3'h0, feedforward_cap_select, ramp_select, slave_fault_detect_off};
        chk("comp fields", 16'(f), 16'h0013);
        ac(1, CMD_VOUT_CTRL, 16'h004B, 0);
        f = {active_discharge_enable, power_good_delay, feedback_divider_select, discharge_on};
        chk("output control fields", 16'(f), 16'h0097);
        ac(1, CMD_OV_THRESHOLDS, 16'h00FE, 0);
        ac(0, CMD_OV_THRESHOLDS, 0, 16'h000E);
        f = {4'h0, overvoltage_exit_level, overvoltage_entry_level};
        chk("threshold fields", 16'(f), 16'h000E);
        ac(1, CMD_OV_RESPONSE, 16'h00FF, 0);
        ac(0, CMD_OV_RESPONSE, 0, 16'h0000);
        ac(0, CMD_VOUT_READING, 0, 16'h1FFF);
        ac(0, CMD_IOUT_READING, 0, 16'h3FFF);
        fault_cond_pins = 15'h0011;
        #300;
        fault_cond_pins = 15'h0010;
        #300;
        ac(0, CMD_OUTPUT_VOLTAGE_SUMMARY, 0, 16'h0080);
        ac(0, CMD_SUMMARY_WORD, 0, 16'hC030);
        ac(1, CMD_CLEAR_FAULTS, 0, 0);
        ac(0, CMD_OUTPUT_VOLTAGE_SUMMARY, 0, 16'h0000);
        ac(0, CMD_OUTPUT_CURRENT_SUMMARY, 0, 16'h0080);
        fault_cond_pins = 15'h7FEE;
        #300;
        ac(0, CMD_OUTPUT_VOLTAGE_SUMMARY, 0, 16'h0019);
        ac(0, CMD_OUTPUT_CURRENT_SUMMARY, 0, 16'h00E0);
        ac(0, CMD_INPUT_STATUS, 0, 16'h00F0);
        ac(0, CMD_COMMS_STATUS, 0, 16'h0013);
        ac(0, CMD_SUMMARY_WORD, 0, 16'hE15B);
        {fault_cond_pins, temp_meas} = {15'h0000, 10'd160};
        #300;
        ac(0, CMD_TEMP_STATUS, 0, 16'h00C0);
        ac(0, CMD_TEMP_READING, 0, 16'h00A0);
        chk("alert", 16'(alert_output_oe), 16'h0001);
        chk("alert level", 16'(alert_output_o), 16'h0000);
        temp_meas = 10'h000;
        ac(0, CMD_VIN_READING, 0, 16'h03FF);
        ac(1, CMD_CLEAR_FAULTS, 0, 0);
        chk("alert released", 16'(alert_output_oe), 16'h0000);
        cmd_bad_data = 1'b1;
        ac(1, CMD_SUMMARY_BYTE, 0, 0);
        cmd_bad_data = 1'b0;
        chk("unsupported", 16'(r[0]), 16'h0001);
        ac(0, CMD_COMMS_STATUS, 0, 16'h00C0);
        {operation_off, control_pin} = 2'b11;
        #300;
        ac(0, CMD_SUMMARY_BYTE, 0, 16'h0042);
        chk("discharge", 16'(discharge_on), 16'h0000);
        $display("test status and configuration sequence done");
        print_verdict();
    end
endmodule : pmbus_status_telemetry_config_regs_bench
